// *** verif/testbench.sv ***
// self-checking bench for txsel_top
// assumes design, checker, mac model
`timescale 1ns/1ps
`include "txsel_defs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
    import txsel_pkg::*;
    typedef struct packed {txsel_mac_stat_t st; logic [15:0] tag; logic [31:0] exp;} txsel_row_t;
    localparam logic [7:0] AD = `TXSEL_ADDR_DATA, AS = `TXSEL_ADDR_STATUS;
    localparam logic [7:0] AC = `TXSEL_ADDR_CONFIG, AI = `TXSEL_ADDR_INFO;
    localparam logic [31:0] ONE = 32'h0000_3004;
    logic ref_clk, sys_rst = 1'b1, stall = 1'b0, macWordValid, macWordReady, macDone;
    logic transmitter_error_flag;
    txsel_bus_t bus = '0;
    txsel_word_t macWord;
    txsel_mac_stat_t macStat, statIn = '0;
    logic [31:0] busRdata;
    int fails = 0, n_compared = 0, i;
    // mac outcome, tag, expected status
    txsel_row_t rows [6] = '{'{10'h200, 16'h1111, 32'h1111_8800},
        '{10'h100, 16'h2222, 32'h2222_8400}, '{10'h080, 16'h3333, 32'h3333_8200},
        '{10'h040, 16'h4444, 32'h4444_8100}, '{10'h020, 16'h5555, 32'h5555_0000},
        '{10'h01f, 16'h6666, 32'h6666_0079}};
    txsel_top #(.DF_DEPTH(4), .SF_DEPTH(2)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
        .busRdata(busRdata), .macWordValid(macWordValid), .macWord(macWord),
        .macWordReady(macWordReady), .macDone(macDone), .macStat(macStat),
        .transmitter_error_flag(transmitter_error_flag));
    txsel_mac_model mac (.ref_clk(ref_clk), .sys_rst(sys_rst), .wordValid(macWordValid),
        .word(macWord), .wordReady(macWordReady), .stall(stall), .statIn(statIn),
        .done(macDone), .stat(macStat));
    // one strobe cycle, then idle
    task automatic wr(input logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] e);
        @(posedge ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk) bus <= '0;
        #1 `CHK("read", e, busRdata)
    endtask
    task automatic pkt(input logic [15:0] t, logic [31:0] a, logic [10:0] len);
        wr(AD, a);
        wr(AD, {t, 5'h0, len});
        for (int k = 0; k < (a[10:0] + 3) / 4; k++) wr(AD, 32'h0);
    endtask
    task automatic waitDone;
        for (int k = 0; k < 40 && macDone !== 1'b1; k++) @(posedge ref_clk) #1;
        `CHK("done", 1'b1, macDone)
        @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // watchdog, well past test length
    initial begin
        #100us;
        fails++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 `CHK("valid", 1'b0, macWordValid)
        for (i = 0; i < 6; i++) begin
            statIn <= rows[i].st;
            pkt(rows[i].tag, ONE, 11'd4);
            waitDone;
            rd(AS, rows[i].exp);
        end
        statIn <= 10'h020;
        wr(AC, 32'h2);
        pkt(16'h7777, ONE, 11'd4);
        waitDone;
        rd(AS, 32'h7777_8004);
        // full status store, no discard: sending waits
        statIn <= '0;
        wr(AC, 32'h0);
        pkt(16'h00a1, ONE, 11'd4);
        waitDone;
        pkt(16'h00a2, ONE, 11'd4);
        waitDone;
        pkt(16'h00a3, ONE, 11'd4);
        repeat (8) @(posedge ref_clk);
        #1 `CHK("stall", 1'b0, macWordValid)
        rd(AS, 32'h00a1_0000);
        waitDone;
        rd(AS, 32'h00a2_0000);
        rd(AS, 32'h00a3_0000);
        wr(AC, 32'h1);
        for (i = 0; i < 3; i++) begin
            pkt(16'h00b0 + 16'(i), ONE, 11'd4);
            waitDone;
        end
        `CHK("overrun", 1'b0, transmitter_error_flag)
        rd(AS, 32'h00b0_0000);
        rd(AS, 32'h00b1_0000);
        rd(AS, 32'h0);
        pkt(16'h00c0, ONE, 11'd5);
        waitDone;
        `CHK("length", 1'b1, transmitter_error_flag)
        wr(AI, 32'h8000_0000);
        pkt(16'h00c1, 32'h0000_2004, 11'd8);
        pkt(16'h00c2, 32'h0000_1004, 11'd8);
        waitDone;
        `CHK("cmd b", 1'b1, transmitter_error_flag)
        rd(AS, 32'h00c0_0000);
        wr(AI, 32'h8000_0000);
        stall <= 1'b1;
        pkt(16'h00d0, 32'h0000_3018, 11'd24);
        #1 `CHK("data ovr", 1'b1, transmitter_error_flag)
        end_of_test;
    end
endmodule
bind txsel_top txsel_top_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
    .busRdata(busRdata), .macWordValid(macWordValid), .macWord(macWord),
    .macWordReady(macWordReady), .macDone(macDone),
    .transmitter_error_flag(transmitter_error_flag));

// *** verif/txsel_mac_model.sv ***
// mac engine model: one outcome per packet
// assumes eof marks packet end
`timescale 1ns/1ps
module txsel_mac_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // word stream
    input wire logic wordValid,
    input wire txsel_pkg::txsel_word_t word,
    output logic wordReady,
    input wire logic stall,
    // outcome
    input wire txsel_pkg::txsel_mac_stat_t statIn,
    output logic done,
    output txsel_pkg::txsel_mac_stat_t stat
);
    import txsel_pkg::*;
    assign wordReady = !stall;
    // scrambled between pulses
    always_ff @(posedge ref_clk) begin
        done <= !sys_rst && wordValid && wordReady && word.eof;
        stat <= (wordValid && wordReady && word.eof) ? statIn : ~statIn;
    end
endmodule

// *** verif/txsel_top_assertions.sv ***
// port checker for txsel_top
// assumes it is bound to txsel_top
`timescale 1ns/1ps
`include "txsel_defs.svh"
module txsel_top_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // watched ports
    input wire txsel_pkg::txsel_bus_t bus,
    input wire logic [31:0] busRdata,
    input wire logic macWordValid,
    input wire txsel_pkg::txsel_word_t macWord,
    input wire logic macWordReady,
    input wire logic macDone,
    input wire logic transmitter_error_flag
);
    import txsel_pkg::*;
    logic discardReg;
    // shadow of discard mode
    always_ff @(posedge ref_clk) begin
        if (sys_rst) discardReg <= 1'b0;
        else if (bus.wr && bus.addr == `TXSEL_ADDR_CONFIG) discardReg <= bus.wdata[0];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_statRd; bus.rd && bus.addr == `TXSEL_ADDR_STATUS; endsequence
    property p_es; s_statRd |=> busRdata[15] == |{busRdata[11:8], busRdata[2:1]}; endproperty
    a_es: assert property (p_es) else $error("summary bit wrong");
    property p_rsvd; s_statRd |=> busRdata[14:12] == 3'h0 && !busRdata[7] && !busRdata[1]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_idle; !bus.rd |=> busRdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_sticky;
        transmitter_error_flag && !(bus.wr && bus.addr == `TXSEL_ADDR_INFO && bus.wdata[31])
            |=> transmitter_error_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    // discard on: no overrun error
    property p_disc;
        discardReg && !bus.wr && !transmitter_error_flag |=> !transmitter_error_flag;
    endproperty
    a_disc: assert property (p_disc) else $error("overrun error");
    property p_nohalt;
        $rose(transmitter_error_flag) && $past(macWordValid && !macWordReady && !macDone)
            |-> macWordValid;
    endproperty
    a_nohalt: assert property (p_nohalt) else $error("sending halted");
    property p_hold; macWordValid && !macWordReady |=> $stable(macWord); endproperty
    a_hold: assert property (p_hold) else $error("head word moved");
endmodule

// *** verilog/txsel_cmd_decode.sv ***
// sorts the dwords of a host buffer into dropped offset, kept data and dropped padding
// assumes the command word is held stable by the caller
`timescale 1ns/1ps
`include "txsel_defs.svh"

module txsel_cmd_decode (
    // first command word
    input wire logic [31:0] cmdA,
    // buffer plan
    output txsel_pkg::txsel_plan_t plan
);
    import txsel_pkg::*;

    // ---------------------------------------------------------------
    // dword arithmetic
    // ---------------------------------------------------------------
    // bytes rounded up to whole dwords
    function automatic logic [9:0] ceilDw(input logic [11:0] bytes);
        logic [11:0] sum;
        sum = bytes + 12'h003;
        return sum[11:2];
    endfunction

    logic [4:0] offset;
    logic [10:0] size;
    logic [9:0] rawDw;
    logic [9:0] alignDw;
    logic [9:0] padded;

    assign offset = cmdA[`TXSEL_A_OFFSET];
    assign size = cmdA[`TXSEL_A_SIZE];

    // whole dwords of offset are stripped, a partial one stays
    assign plan.dropFront = {7'h00, offset[4:2]};
    assign plan.keep = ceilDw({1'b0, size} + {10'h000, offset[1:0]});
    assign rawDw = ceilDw({1'b0, size} + {7'h00, offset});

    // end alignment widens the host buffer, never the kept data
    always_comb begin
        case (cmdA[`TXSEL_A_ALIGN])
            2'h1: alignDw = 10'(`TXSEL_ALIGN16_DW);
            2'h2: alignDw = 10'(`TXSEL_ALIGN32_DW);
            default: alignDw = 10'h001;
        endcase
    end

    assign padded = rawDw + alignDw - 10'h001;
    assign plan.total = padded & ~(alignDw - 10'h001);

endmodule

// *** verilog/txsel_defs.svh ***
// constants for the transmit status and error block: offsets, fields, reset values
// assumes inclusion by every design file that decodes the register port or command words
`ifndef TXSEL_DEFS_SVH
`define TXSEL_DEFS_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define TXSEL_ADDR_DATA 8'h00
`define TXSEL_ADDR_STATUS 8'h04
`define TXSEL_ADDR_CONFIG 8'h08
`define TXSEL_ADDR_CSUM 8'h0c
`define TXSEL_ADDR_INFO 8'h10
`define TXSEL_ADDR_USAGE 8'h14

// ---------------------------------------------------------------
// config, checksum control and info bits
// ---------------------------------------------------------------
`define TXSEL_CFG_DISCARD 0
`define TXSEL_CFG_DEFER_CHK 1
`define TXSEL_CSUM_EN 16
`define TXSEL_INFO_TXE 31
`define TXSEL_INFO_CSUM 30
`define TXSEL_INFO_OVR 29
`define TXSEL_INFO_USED_LSB 0
`define TXSEL_INFO_FREE_LSB 8

// ---------------------------------------------------------------
// command word fields
// ---------------------------------------------------------------
`define TXSEL_A_SIZE 10:0
`define TXSEL_A_LAST 12
`define TXSEL_A_FIRST 13
`define TXSEL_A_OFFSET 20:16
`define TXSEL_A_ALIGN 25:24
`define TXSEL_B_TAG 31:16
`define TXSEL_B_CK 14
`define TXSEL_B_LEN 10:0

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define TXSEL_ST_TAG 31:16
`define TXSEL_ST_ES 15
`define TXSEL_ST_LOSS 11
`define TXSEL_ST_NOCAR 10
`define TXSEL_ST_LATE 9
`define TXSEL_ST_EXCOL 8
`define TXSEL_ST_CCNT 6:3
`define TXSEL_ST_EXDEF 2
`define TXSEL_ST_RSVD1 1
`define TXSEL_ST_DEFER 0

// ---------------------------------------------------------------
// sizes and reset values
// ---------------------------------------------------------------
`define TXSEL_DWORD_BYTES 4
`define TXSEL_PREAMBLE_BYTES 4
`define TXSEL_CFG_RESET 32'h0000_0000
`define TXSEL_ALIGN16_DW 4
`define TXSEL_ALIGN32_DW 8

`endif

// *** verilog/txsel_pkg.sv ***
// types shared by the transmit status and error block
// assumes txsel_defs.svh holds all numeric constants
package txsel_pkg;

    // register port request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } txsel_bus_t;

    // per-packet outcome reported by the mac engine
    typedef struct packed {
        logic lossCarrier;
        logic noCarrier;
        logic lateColl;
        logic excessColl;
        logic excessDefer;
        logic deferred;
        logic [3:0] collCount;
    } txsel_mac_stat_t;

    // one kept data word handed to the mac
    typedef struct packed {
        logic [15:0] tag;
        logic sof;
        logic eof;
        logic [31:0] data;
    } txsel_word_t;

    // how the dwords of one host buffer are sorted
    typedef struct packed {
        logic [9:0] dropFront;
        logic [9:0] keep;
        logic [9:0] total;
    } txsel_plan_t;

    // host buffer parser states
    typedef enum logic [1:0] {
        SEEK_A,
        SEEK_B,
        DATA
    } txsel_state_t;

endpackage

// *** verilog/txsel_status_fifo.sv ***
// first-in first-out store of transmit status words
// assumes the caller never pushes when full nor pops when empty
`timescale 1ns/1ps

module txsel_status_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // write side
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    // read side
    input wire logic pop,
    output logic [WIDTH-1:0] popData,
    // occupancy
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;

    // ---------------------------------------------------------------
    // storage and pointers
    // ---------------------------------------------------------------
    // storage needs no reset; pointers define what is valid
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_reg[AW-1:0]] <= pushData;
        end
    end

    // pointers carry one extra bit to tell full from empty
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end

    assign count = wrPtr_reg - rdPtr_reg;
    assign full = (count == (AW+1)'(DEPTH));
    assign empty = (count == '0);
    assign popData = mem[rdPtr_reg[AW-1:0]];

endmodule

// *** verilog/txsel_top.sv ***
// transmit status and error bookkeeping of a 10/100 ethernet controller
// assumes one clock, synchronous reset, software on a plain strobe port and a mac engine
// that takes kept data words and reports one outcome per packet
//
// Summary of operation
// - one status word per packet, in order
// - full status store stalls data transmission
// - discard mode keeps sending, drops overrun status
// - discard mode status overrun raises no error
// - status top half carries packet tag
// - error summary ORs error status bits
// - reserved status bits read zero
// - loss of carrier reported in bit 11
// - no carrier in bit 10, ignore full-duplex
// - late collision reported in bit 9
// - sixteen collisions abort, bit 8
// - collision count in field 6:3
// - excessive deferral bit when checking enabled
// - deferred bit reported in bit 0
// - command A and B for every segment, B repeated
// - checksum preamble occupies four data bytes
// - whole offset and padding dwords stripped
// - error flag never halts the transmitter
// - length mismatch raises error flag
// - differing second command word raises error
// - data or status overrun raises error
// - checksum needs request, first segment, enable
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "txsel_defs.svh"

module txsel_top #(
    parameter int DF_DEPTH = 16,
    parameter int SF_DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire txsel_pkg::txsel_bus_t bus,
    output logic [31:0] busRdata,
    // kept data words to the mac
    output logic macWordValid,
    output txsel_pkg::txsel_word_t macWord,
    input wire logic macWordReady,
    // per-packet outcome from the mac
    input wire logic macDone,
    input wire txsel_pkg::txsel_mac_stat_t macStat,
    // error flag level
    output logic transmitter_error_flag
);
    import txsel_pkg::*;

    localparam int DAW = $clog2(DF_DEPTH);
    localparam int SAW = $clog2(SF_DEPTH);

    // ---------------------------------------------------------------
    // register port decode
    // ---------------------------------------------------------------
    logic dataWr;
    logic cfgWr;
    logic csumWr;
    logic infoWr;
    logic statusRd;

    assign dataWr = bus.wr && (bus.addr == `TXSEL_ADDR_DATA);
    assign cfgWr = bus.wr && (bus.addr == `TXSEL_ADDR_CONFIG);
    assign csumWr = bus.wr && (bus.addr == `TXSEL_ADDR_CSUM);
    assign infoWr = bus.wr && (bus.addr == `TXSEL_ADDR_INFO);
    assign statusRd = bus.rd && (bus.addr == `TXSEL_ADDR_STATUS);

    logic [31:0] config_reg;
    logic [31:0] csumCtrl_reg;
    logic status_discard_overrun_enable;
    logic deferCheckEnable;
    logic tx_checksum_offload_enable;

    // software controls
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            config_reg <= `TXSEL_CFG_RESET;
            csumCtrl_reg <= `TXSEL_CFG_RESET;
        end else begin
            if (cfgWr) begin
                config_reg <= bus.wdata;
            end
            if (csumWr) begin
                csumCtrl_reg <= bus.wdata;
            end
        end
    end

    assign status_discard_overrun_enable = config_reg[`TXSEL_CFG_DISCARD];
    assign deferCheckEnable = config_reg[`TXSEL_CFG_DEFER_CHK];
    assign tx_checksum_offload_enable = csumCtrl_reg[`TXSEL_CSUM_EN];

    // ---------------------------------------------------------------
    // tx data store
    // ---------------------------------------------------------------
    txsel_word_t dataMem [DF_DEPTH];
    logic [DAW:0] dfWr_reg;
    logic [DAW:0] dfRd_reg;
    logic [DAW:0] dfCount;
    logic dfFull;
    logic dfPush;
    logic dfPop;
    txsel_word_t dfIn;
    logic statusHold;

    assign dfCount = dfWr_reg - dfRd_reg;
    assign dfFull = (dfCount == (DAW+1)'(DF_DEPTH));
    // a full status store stops words leaving, unless overrun is allowed
    assign macWordValid = (dfCount != '0) && !statusHold;
    assign macWord = dataMem[dfRd_reg[DAW-1:0]];
    assign dfPop = macWordValid && macWordReady;

    always_ff @(posedge ref_clk) begin
        if (dfPush) begin
            dataMem[dfWr_reg[DAW-1:0]] <= dfIn;
        end
    end

    // store pointers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dfWr_reg <= '0;
            dfRd_reg <= '0;
        end else begin
            if (dfPush) begin
                dfWr_reg <= dfWr_reg + 1'b1;
            end
            if (dfPop) begin
                dfRd_reg <= dfRd_reg + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // host buffer parser
    // ---------------------------------------------------------------
    txsel_state_t state_reg;
    logic [31:0] cmdA_reg;
    logic [31:0] cmdB_reg;
    logic [9:0] idx_reg;
    logic [11:0] pktBytes_reg;
    logic csumApply_reg;
    logic [15:0] useCmd_reg;
    logic [15:0] useData_reg;
    txsel_plan_t plan;
    logic overrunWr;
    logic takeWr;
    logic firstSeg;
    logic lastSeg;
    logic keepWord;
    logic bufEnd;
    logic [11:0] bufSum;
    logic [11:0] expectLen;
    logic lenErr;
    logic cmdBErr;

    txsel_cmd_decode u_decode (
        .cmdA(cmdA_reg),
        .plan(plan)
    );

    // writes into a full store are lost and flagged
    assign overrunWr = dataWr && dfFull;
    assign takeWr = dataWr && !dfFull;
    assign firstSeg = cmdA_reg[`TXSEL_A_FIRST];
    assign lastSeg = cmdA_reg[`TXSEL_A_LAST];

    // only the dwords between stripped offset and stripped padding are stored
    assign keepWord = (state_reg == DATA) && (idx_reg >= plan.dropFront)
        && (idx_reg < plan.dropFront + plan.keep);
    assign dfPush = takeWr && keepWord;
    assign dfIn.data = bus.wdata;
    assign dfIn.tag = cmdB_reg[`TXSEL_B_TAG];
    assign dfIn.sof = firstSeg && (idx_reg == plan.dropFront);
    assign dfIn.eof = lastSeg && (idx_reg == plan.dropFront + plan.keep - 10'h001);

    // buffer ends on its last host dword, or at command B for an empty buffer
    assign bufEnd = takeWr && (((state_reg == DATA) && (idx_reg == plan.total - 10'h001))
        || ((state_reg == SEEK_B) && (plan.total == '0)));

    // payload bytes so far; the preamble does not count toward the length
    assign bufSum = (firstSeg ? 12'h000 : pktBytes_reg) + {1'b0, cmdA_reg[`TXSEL_A_SIZE]};
    assign expectLen = {1'b0, cmdB_reg[`TXSEL_B_LEN]}
        + (csumApply_reg ? 12'(`TXSEL_PREAMBLE_BYTES) : 12'h000);
    assign lenErr = bufEnd && lastSeg && (bufSum != expectLen);

    // a later buffer must repeat the packet's command B word
    assign cmdBErr = takeWr && (state_reg == SEEK_B) && !firstSeg && (bus.wdata != cmdB_reg);

    // parser sequence: command A, command B, host dwords
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= SEEK_A;
            idx_reg <= '0;
        end else if (takeWr) begin
            case (state_reg)
                SEEK_A: begin
                    state_reg <= SEEK_B;
                end
                SEEK_B: begin
                    state_reg <= (plan.total == '0) ? SEEK_A : DATA;
                    idx_reg <= '0;
                end
                DATA: begin
                    state_reg <= bufEnd ? SEEK_A : DATA;
                    idx_reg <= idx_reg + 10'h001;
                end
                default: begin
                    state_reg <= SEEK_A;
                end
            endcase
        end
    end

    // command words and packet byte total
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmdA_reg <= '0;
            cmdB_reg <= '0;
            pktBytes_reg <= '0;
            csumApply_reg <= 1'b0;
        end else begin
            if (takeWr && state_reg == SEEK_A) begin
                cmdA_reg <= bus.wdata;
            end
            // the packet's own B word is kept from its first segment only
            if (takeWr && state_reg == SEEK_B && firstSeg) begin
                cmdB_reg <= bus.wdata;
                csumApply_reg <= bus.wdata[`TXSEL_B_CK] && tx_checksum_offload_enable;
            end
            if (bufEnd) begin
                pktBytes_reg <= bufSum;
            end
        end
    end

    // data store usage of the current packet, in bytes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            useCmd_reg <= '0;
            useData_reg <= '0;
        end else if (takeWr) begin
            // command A counts for every buffer, B for the first only
            if (state_reg == SEEK_A) begin
                useCmd_reg <= (bus.wdata[`TXSEL_A_FIRST] ? 16'h0000 : useCmd_reg)
                    + 16'(`TXSEL_DWORD_BYTES);
                useData_reg <= bus.wdata[`TXSEL_A_FIRST] ? 16'h0000 : useData_reg;
            end
            if (state_reg == SEEK_B && firstSeg) begin
                useCmd_reg <= useCmd_reg + 16'(`TXSEL_DWORD_BYTES);
            end
            // kept words include the preamble dword when offload applies
            if (keepWord) begin
                useData_reg <= useData_reg + 16'(`TXSEL_DWORD_BYTES);
            end
        end
    end

    // ---------------------------------------------------------------
    // status word assembly
    // ---------------------------------------------------------------
    logic [15:0] tagInFlight_reg;
    logic [31:0] statusWord;
    logic exDefer;

    // tag follows the packet the mac started last; mac finishes in order
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tagInFlight_reg <= '0;
        end else if (dfPop && macWord.sof) begin
            tagInFlight_reg <= macWord.tag;
        end
    end

    assign exDefer = macStat.excessDefer && deferCheckEnable;

    // fields not named stay zero, which keeps reserved bits clear
    always_comb begin
        statusWord = '0;
        statusWord[`TXSEL_ST_TAG] = tagInFlight_reg;
        statusWord[`TXSEL_ST_LOSS] = macStat.lossCarrier;
        statusWord[`TXSEL_ST_NOCAR] = macStat.noCarrier;
        statusWord[`TXSEL_ST_LATE] = macStat.lateColl;
        statusWord[`TXSEL_ST_EXCOL] = macStat.excessColl;
        statusWord[`TXSEL_ST_CCNT] = macStat.collCount;
        statusWord[`TXSEL_ST_EXDEF] = exDefer;
        statusWord[`TXSEL_ST_DEFER] = macStat.deferred;
        statusWord[`TXSEL_ST_ES] = macStat.lossCarrier | macStat.noCarrier
            | macStat.lateColl | macStat.excessColl | exDefer
            | statusWord[`TXSEL_ST_RSVD1];
    end

    // ---------------------------------------------------------------
    // status store and overrun handling
    // ---------------------------------------------------------------
    logic sfPush;
    logic sfPop;
    logic sfFull;
    logic sfEmpty;
    logic [SAW:0] sfCount;
    logic [31:0] sfHead;
    logic sfOverrun;
    logic overrun_reg;

    // one push per finished packet while room remains and no overrun is pending
    assign sfPush = macDone && !sfFull && !overrun_reg;
    assign sfPop = statusRd && !sfEmpty;
    assign sfOverrun = macDone && (sfFull || overrun_reg);
    assign statusHold = sfFull && !status_discard_overrun_enable;

    txsel_status_fifo #(
        .WIDTH(32),
        .DEPTH(SF_DEPTH)
    ) u_status (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .push(sfPush),
        .pushData(statusWord),
        .pop(sfPop),
        .popData(sfHead),
        .full(sfFull),
        .empty(sfEmpty),
        .count(sfCount)
    );

    // overrun holds off status writes until software reads one; set wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            overrun_reg <= 1'b0;
        end else if (sfOverrun) begin
            overrun_reg <= 1'b1;
        end else if (sfPop) begin
            overrun_reg <= 1'b0;
        end
    end

    // used count reads zero after an overrun, else tracks pushes and pops
    logic [7:0] status_fifo_used_count;
    assign status_fifo_used_count = overrun_reg ? 8'h00 : 8'(sfCount);

    // ---------------------------------------------------------------
    // transmitter error flag
    // ---------------------------------------------------------------
    logic errSet;
    logic errClr;

    // status overrun only counts when overrun is not allowed
    assign errSet = overrunWr || lenErr || cmdBErr
        || (sfOverrun && !status_discard_overrun_enable);
    assign errClr = infoWr && bus.wdata[`TXSEL_INFO_TXE];

    // sticky; a new cause in the clearing cycle wins; nothing here stalls the mac
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            transmitter_error_flag <= 1'b0;
        end else begin
            transmitter_error_flag <= errSet || (transmitter_error_flag && !errClr);
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [31:0] rdNext;

    always_comb begin
        rdNext = '0;
        case (bus.addr)
            `TXSEL_ADDR_STATUS: rdNext = sfEmpty ? 32'h0000_0000 : sfHead;
            `TXSEL_ADDR_CONFIG: rdNext = config_reg;
            `TXSEL_ADDR_CSUM: rdNext = csumCtrl_reg;
            `TXSEL_ADDR_INFO: begin
                rdNext[`TXSEL_INFO_TXE] = transmitter_error_flag;
                rdNext[`TXSEL_INFO_CSUM] = csumApply_reg;
                rdNext[`TXSEL_INFO_OVR] = overrun_reg;
                rdNext[`TXSEL_INFO_USED_LSB +: 8] = status_fifo_used_count;
                rdNext[`TXSEL_INFO_FREE_LSB +: 8] = 8'(DF_DEPTH) - 8'(dfCount);
            end
            `TXSEL_ADDR_USAGE: rdNext = {useCmd_reg, useData_reg};
            default: rdNext = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busRdata <= '0;
        end else begin
            busRdata <= bus.rd ? rdNext : 32'h0000_0000;
        end
    end

endmodule
